// *** wit_regs.vh ***
// Register map, field layout and constants of the watchdog / interval timer.
// Assumes inclusion by the timer design files and the testbench; holds definitions only.
`ifndef WIT_REGS_VH
`define WIT_REGS_VH

// Register indices; byte address is four times the index
`define WIT_IDX_CTRL      10'h0c9
`define WIT_IDX_STAT      10'h0ca
`define WIT_IDX_MASK      10'h0cb

// Control register field positions
`define WIT_CLR_HI        7
`define WIT_CLR_LO        4
`define WIT_EN_BIT        3
`define WIT_MODE_BIT      2
`define WIT_INT_HI        1
`define WIT_INT_LO        0

// Clear sequence codes
`define WIT_CODE_FIRST    4'ha
`define WIT_CODE_SECOND   4'h5

// Reset values
`define WIT_CTRL_RST      8'h00
`define WIT_CLR_RST       4'h0
`define WIT_MASK_RST      1'h0
`define WIT_CNT_RST       15'h0000

// Mode bit values
`define WIT_MODE_WDOG     1'h0
`define WIT_MODE_TIMER    1'h1

// Interval select codes and counts in low-speed periods
`define WIT_INT_SEL0      2'h0
`define WIT_INT_SEL1      2'h1
`define WIT_INT_SEL2      2'h2
`define WIT_IVL_SEL0      16'h8000
`define WIT_IVL_SEL1      16'h2000
`define WIT_IVL_SEL2      16'h0200
`define WIT_IVL_SEL3      16'h0040

// Status bit position of the timer flag
`define WIT_STAT_FLAG     0

// AXI responses
`define WIT_RESP_OKAY     2'h0
`define WIT_RESP_SLVERR   2'h2

`endif

// *** wit_sync.v ***
// Three-flop synchroniser with change detection for one asynchronous input.
// Assumes the input is slow compared with aclk; a change counts once the
// second and third stages agree.
`timescale 1ns/1ns
`default_nettype none

module wit_sync (
   input  wire aclk,
   input  wire aresetn,
   input  wire async_in,
   output reg  level_q,
   output reg  rise_q,
   output reg  change_q
);

   reg s1_q;   // First stage, read only by the second
   reg s2_q;   // Second stage
   reg s3_q;   // Third stage

   // Shift chain and filtered level
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1_q     <= 1'b0;
         s2_q     <= 1'b0;
         s3_q     <= 1'b0;
         level_q  <= 1'b0;
         rise_q   <= 1'b0;
         change_q <= 1'b0;
      end else begin
         s1_q     <= async_in;
         s2_q     <= s1_q;
         s3_q     <= s2_q;
         rise_q   <= 1'b0;
         change_q <= 1'b0;
         // Accept a new level only when stages two and three agree
         if ((s2_q == s3_q) && (s3_q != level_q)) begin
            level_q  <= s3_q;
            rise_q   <= s3_q;
            change_q <= 1'b1;
         end
      end
   end

endmodule // wit_sync

`default_nettype wire

// *** wit_top.v ***
// Watchdog and interval timer with an AXI4-Lite register slave.
// Assumes lsclk_in is a free-running low-speed oscillator far slower than
// aclk; the system reset request is cleared only by aresetn.
//
// Overview of operation
// RL1: Code 1010 then 0101 clears the counter.
// RL2: Second code must come within half period.
// RL3: Clear field writes ignored while disabled.
// RL4: Enable bit one starts counter incrementing.
// RL5: Timer mode: enable zero stops counter.
// RL6: Watchdog mode: enable zero has no effect.
// RL7: Interval select picks 32768, 8192, 512, 64.
// RL8: Mode zero watchdog, mode one timer.
// RL9: After reset disabled, all fields zero.
// RL10: Watchdog timeout asserts system reset request.
// RL11: Timer timeout sets flag, interrupt if enabled.
// RL12: Low-speed clock synchronised safely into system domain.
`timescale 1ns/1ns
`default_nettype none
`include "wit_regs.vh"

module wit_top #(
   parameter CNT_W  = 15,   // Counter width
   parameter ADDR_W = 12    // AXI address width
) (
   input  wire              aclk,
   input  wire              aresetn,
   input  wire              lsclk_in,
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   output reg               irq_q,
   output reg               sys_reset_req_q
);

   // Timeout count for an interval select code
   // The counts are compared against the counter plus one, so the
   // timeout falls on the low-speed rise that completes the interval.
   // Three two-bit codes are listed; the default branch takes the fourth and keeps the
   // decode total so that no latch-like hold can appear.
   function [15:0] ivl_count;
      input [1:0] sel;
      begin
         case (sel)
            `WIT_INT_SEL0: ivl_count = `WIT_IVL_SEL0;
            `WIT_INT_SEL1: ivl_count = `WIT_IVL_SEL1;
            `WIT_INT_SEL2: ivl_count = `WIT_IVL_SEL2;
            default:       ivl_count = `WIT_IVL_SEL3;
         endcase
      end
   endfunction

   // Register index of a byte address
   // Word addresses are decoded; the two low address bits are
   // dropped, so byte offsets inside a word alias one register.
   function [9:0] reg_index;
      input [ADDR_W-1:0] addr;
      begin
         reg_index = addr[11:2];
      end
   endfunction

   // Control register fields
   reg [3:0]       clr_q;      // Last accepted clear code
   reg             en_q;       // Timer enabled
   reg             mode_q;     // Watchdog or timer mode
   reg [1:0]       ivl_q;      // Interval select
   // Counter and clear sequence state
   reg [CNT_W-1:0] cnt_q;      // Low-speed period counter
   reg             armed_q;    // First clear code seen
   // Interrupt registers
   reg             flag_q;     // Sticky timer flag
   reg             mask_q;     // Interrupt enable
   // AXI write holding
   reg             aw_have_q;  // Address held
   reg [ADDR_W-1:0] aw_addr_q; // Held write address
   reg             w_have_q;   // Data held
   reg [31:0]      w_data_q;   // Held write data
   reg [3:0]       w_strb_q;   // Held byte enables

   // Low-speed clock level and edges
   wire ls_rise;
   wire ls_change;
   wire ls_level;

   // Bring the oscillator into the aclk domain
   // The oscillator is sampled, not used as a clock, so the block stays
   // in one clock domain and no control word has to cross into a slow
   // domain. The price: each oscillator phase must last several aclk
   // periods, at least two of them, or level changes are missed.
   wit_sync u_ls_sync (                                     // RL12
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (lsclk_in),
      .level_q  (ls_level),
      .rise_q   (ls_rise),
      .change_q (ls_change)
   );

   // Write decode
   // A write is performed once both halves are held and no response is
   // waiting, so at most one write is in flight at any time.
   // Only byte lane zero carries register bits; other lanes are dropped.
   wire        wr_fire  = aw_have_q && w_have_q && !s_axi_bvalid;
   wire [9:0]  wr_idx   = reg_index(aw_addr_q);
   wire        wr_ctrl  = wr_fire && (wr_idx == `WIT_IDX_CTRL) && w_strb_q[0];
   wire        wr_mask  = wr_fire && (wr_idx == `WIT_IDX_MASK) && w_strb_q[0];
   wire        wr_known = (wr_idx == `WIT_IDX_CTRL) || (wr_idx == `WIT_IDX_STAT) ||
                          (wr_idx == `WIT_IDX_MASK);
   wire [7:0]  wbyte    = w_data_q[7:0];
   wire [3:0]  wclr     = wbyte[`WIT_CLR_HI:`WIT_CLR_LO];

   // Read decode
   // The read address is decoded straight from the bus because it is
   // taken and answered at the same edge; a status read clears the flag.
   wire        rd_fire  = s_axi_arvalid && s_axi_arready;
   wire [9:0]  rd_idx   = reg_index(s_axi_araddr);
   wire        rd_stat  = rd_fire && (rd_idx == `WIT_IDX_STAT);

   // Clear sequence decode; codes only count while enabled
   // A disabled timer neither stores the clear field nor arms on it,
   // so stray codes written before enabling cannot start a sequence.
   wire clr_first  = wr_ctrl && en_q && (wclr == `WIT_CODE_FIRST);   // RL3
   wire clr_second = wr_ctrl && en_q && armed_q &&
                     (wclr == `WIT_CODE_SECOND);                     // RL1
   // Timer mode also clears on a one in the lowest clear bit
   wire clr_timer  = wr_ctrl && en_q && (mode_q == `WIT_MODE_TIMER) &&
                     wbyte[`WIT_CLR_LO];
   wire cnt_clear  = clr_second || clr_timer;

   // Enable and mode write decode
   // Once the watchdog runs it cannot be stopped or switched to timer
   // mode; only a system reset releases this lock.
   wire wdog_lock  = en_q && (mode_q == `WIT_MODE_WDOG);             // RL6
   wire en_set     = wr_ctrl && wbyte[`WIT_EN_BIT];                  // RL4
   wire en_drop    = wr_ctrl && !wbyte[`WIT_EN_BIT] && !wdog_lock;   // RL5
   wire en_start   = en_set && !en_q;

   // Timeout: next count reaches the selected interval
   // The sum is one bit wider than the counter so that the longest
   // interval is reached without the counter wrapping first.
   wire [15:0] cnt_next = {{(16-CNT_W){1'b0}}, cnt_q} + 16'h0001;
   wire        timeout  = en_q && ls_rise && (cnt_next == ivl_count(ivl_q)); // RL7

   // Control register fields and clear arming
   // The interval field stays writable in both modes; software should
   // follow an interval change with a clear, or a shorter new limit
   // may already lie behind the current count.
   always @(posedge aclk) begin
      if (!aresetn) begin                                   // RL9
         clr_q   <= `WIT_CLR_RST;
         en_q    <= 1'b0;
         mode_q  <= `WIT_MODE_WDOG;
         ivl_q   <= `WIT_INT_SEL0;
         armed_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            // Interval is always writable
            ivl_q <= wbyte[`WIT_INT_HI:`WIT_INT_LO];
            // Mode is frozen once the watchdog runs
            if (!wdog_lock) begin
               mode_q <= wbyte[`WIT_MODE_BIT];              // RL8
            end
            // Enable sets on one, drops only outside watchdog lock
            if (en_set) begin
               en_q <= 1'b1;                                // RL4
            end else if (en_drop) begin
               en_q <= 1'b0;                                // RL5
            end
            // Clear field stores only while enabled
            if (en_q) begin
               clr_q <= wclr;                               // RL3
            end
         end
         // Arm on first code, disarm on any other control write
         if (clr_first) begin
            armed_q <= 1'b1;                                // RL1
         end else if (wr_ctrl) begin
            armed_q <= 1'b0;
         end else if (ls_change || !en_q) begin
            // Any low-speed level change ends the half-period window
            armed_q <= 1'b0;                                // RL2
         end
      end
   end

   // Low-speed period counter
   // A clear and a timeout in one cycle resolve to the clear, so a
   // sequence completed just in time never raises a reset request.
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= `WIT_CNT_RST;
      end else if (en_start || cnt_clear) begin
         // Restart from zero on enable or completed clear
         cnt_q <= `WIT_CNT_RST;                             // RL1
      end else if (timeout) begin
         // Wrap after each interval
         cnt_q <= `WIT_CNT_RST;
      end else if (en_q && ls_rise) begin
         // Count one low-speed period
         cnt_q <= cnt_next[CNT_W-1:0];                      // RL4
      end
   end

   // System reset request, held until the system reset arrives
   // Sticky on purpose: the system reset it causes is what ends it,
   // so the request cannot be lost before it has been acted on.
   always @(posedge aclk) begin
      if (!aresetn) begin
         sys_reset_req_q <= 1'b0;
      end else if (timeout && !cnt_clear && (mode_q == `WIT_MODE_WDOG)) begin
         sys_reset_req_q <= 1'b1;                           // RL10
      end
   end

   // Sticky timer flag; a timeout wins over a status read
   // An event that meets a read already under way is kept for the
   // next read rather than silently dropped.
   always @(posedge aclk) begin
      if (!aresetn) begin
         flag_q <= 1'b0;
      end else if (timeout && !cnt_clear && (mode_q == `WIT_MODE_TIMER)) begin
         flag_q <= 1'b1;                                    // RL11
      end else if (rd_stat) begin
         flag_q <= 1'b0;
      end
   end

   // Interrupt mask register
   always @(posedge aclk) begin
      if (!aresetn) begin
         mask_q <= `WIT_MASK_RST;
      end else if (wr_mask) begin
         mask_q <= w_data_q[`WIT_STAT_FLAG];
      end
   end

   // Level interrupt from unmasked flag
   // Registered, so it trails the flag by one cycle.
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= flag_q && mask_q;                         // RL11
      end
   end

   // Write address channel: take and hold one address
   // Address and data may arrive in either order; each waits in its
   // own holding register until the other half has come.
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= {ADDR_W{1'b0}};
         s_axi_awready <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end else if (wr_fire) begin
            aw_have_q <= 1'b0;
         end
         // Ready only while nothing is held or pending
         s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) &&
                          !s_axi_bvalid && !wr_fire;
      end
   end

   // Write data channel: take and hold one word
   always @(posedge aclk) begin
      if (!aresetn) begin
         w_have_q     <= 1'b0;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_wready <= 1'b0;
      end else begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_have_q <= 1'b0;
         end
         s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) &&
                         !s_axi_bvalid && !wr_fire;
      end
   end

   // Write response, one cycle after both halves are held
   // The response stands until bready; new writes wait until then.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WIT_RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? `WIT_RESP_OKAY : `WIT_RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Read channel: one read at a time, data registered
   // arready drops for the cycle after a take and while data waits.
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `WIT_RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !rd_fire;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `WIT_RESP_OKAY;
            case (rd_idx)
               `WIT_IDX_CTRL: s_axi_rdata <= {24'h000000, clr_q, en_q, mode_q, ivl_q};
               `WIT_IDX_STAT: s_axi_rdata <= {31'h00000000, flag_q};
               `WIT_IDX_MASK: s_axi_rdata <= {31'h00000000, mask_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `WIT_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // wit_top

`default_nettype wire

// *** wit_top_chk.sv ***
// Checker for the timer top: bus handshakes and the reset request.
// Assumes it is bound to wit_top and sees only its ports.
`timescale 1ns/1ns
`default_nettype none

module wit_top_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        sys_reset_req_q
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Address and data of one write taken at the same edge
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence

   // Read address taken
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence

   wr_resp_a: assert property (wr_taken |-> ##1 !s_axi_bvalid ##1 s_axi_bvalid)
      else $error("write response not two cycles after take");
   rd_resp_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data not one cycle after take");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before bready");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before rready");
   rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address accepted while data pending");
   wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |->
      s_axi_rdata == 32'h0)
      else $error("error read returns nonzero data");
   sysrst_hold_a: assert property (sys_reset_req_q |=> sys_reset_req_q)
      else $error("reset request dropped without reset");
endmodule // wit_top_chk

bind wit_top wit_top_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .sys_reset_req_q);

`default_nettype wire

// *** wit_top_tb.sv ***
// Testbench: register-level tests of the watchdog / interval timer.
// Assumes wit_top, wit_regs.vh and the bound checker are compiled.
`timescale 1ns/1ns
`default_nettype none
`include "wit_regs.vh"

module wit_top_tb;
   logic        aclk = 1'b0;                  // System clock
   logic        aresetn = 1'b0;               // Reset, active low
   logic        lsclk = 1'b0;                 // Low-speed oscillator
   logic [11:0] awaddr = 12'h0;               // Write address
   logic [11:0] araddr = 12'h0;               // Read address
   logic [31:0] wdata = 32'h0;                // Write data
   logic [31:0] rdata;                        // Read data
   logic [1:0]  bresp, rresp;                 // Responses
   logic        awvalid = 1'b0, wvalid = 1'b0; // Write requests
   logic        bready = 1'b0, arvalid = 1'b0; // Write answer, read request
   logic        rready = 1'b0;                // Read answer
   logic        awready, wready, bvalid;      // Write slave outputs
   logic        arready, rvalid;              // Read slave outputs
   logic        irq, sysrst;                  // Interrupt, reset request
   int          miscompares = 0;              // Mismatches
   int          check_count = 0;              // Comparisons
   int          rises = 0;                    // Low-speed rises seen

   wit_top DUT (.aclk(aclk), .aresetn(aresetn), .lsclk_in(lsclk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq_q(irq),
      .sys_reset_req_q(sysrst));

   // Clocks: the slow one is unrelated in phase to aclk
   always #5 aclk = ~aclk;
   always #197 lsclk = ~lsclk;
   always @(posedge lsclk) rises++;

   // Compare and count
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Bus write; address and data offered together
   task wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask

   // Bus read with expected byte and response
   task rd(input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", {24'h0, e}, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask

   // Bounded wait for the interrupt or the reset request
   task wait_hi(input bit sel, input int lim);
      int k;
      k = 0;
      while ((sel ? sysrst : irq) !== 1'b1 && k < lim) begin
         @(posedge aclk);
         k++;
      end
   endtask

   // Wait for some low-speed rises
   task wait_rises(input int r);
      while (rises < r) @(posedge aclk);
   endtask

   // Both clear codes inside one half period of the slow clock
   task clr_pair;
      @(posedge lsclk);
      repeat (5) @(posedge aclk);
      wr(`WIT_IDX_CTRL, 8'hab, `WIT_RESP_OKAY);
      wr(`WIT_IDX_CTRL, 8'h5b, `WIT_RESP_OKAY);
      rises = 0;
   endtask

   // Verdict and end of run
   task final_report;
      if (miscompares == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(`WIT_IDX_CTRL, 8'h00, `WIT_RESP_OKAY);
      rd(`WIT_IDX_STAT, 8'h00, `WIT_RESP_OKAY);
      rd(`WIT_IDX_MASK, 8'h00, `WIT_RESP_OKAY);
      rd(10'h0d0, 8'h00, `WIT_RESP_SLVERR);
      wr(10'h0d0, 8'h0f, `WIT_RESP_SLVERR);
      wr(`WIT_IDX_STAT, 8'h01, `WIT_RESP_OKAY);
      rd(`WIT_IDX_STAT, 8'h00, `WIT_RESP_OKAY);
      // Timer mode, interval 64, interrupt masked
      wr(`WIT_IDX_CTRL, 8'h0f, `WIT_RESP_OKAY);
      rises = 0;
      wait_rises(70);
      chk("irq", 32'h0, {31'h0, irq});
      chk("sysrst", 32'h0, {31'h0, sysrst});
      rd(`WIT_IDX_STAT, 8'h01, `WIT_RESP_OKAY);
      wr(`WIT_IDX_MASK, 8'h01, `WIT_RESP_OKAY);
      rd(`WIT_IDX_MASK, 8'h01, `WIT_RESP_OKAY);
      wait_hi(1'b0, 4000);
      chk("rises", 32'h1, {31'h0, rises >= 127 && rises <= 129});
      rd(`WIT_IDX_STAT, 8'h01, `WIT_RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("irq", 32'h0, {31'h0, irq});
      // Interval 512 from a fresh start
      wr(`WIT_IDX_CTRL, 8'h06, `WIT_RESP_OKAY);
      wr(`WIT_IDX_CTRL, 8'h0e, `WIT_RESP_OKAY);
      rises = 0;
      wait_hi(1'b0, 25000);
      chk("rises", 32'h1, {31'h0, rises >= 511 && rises <= 513});
      rd(`WIT_IDX_STAT, 8'h01, `WIT_RESP_OKAY);
      // Stop in timer mode holds the count
      wr(`WIT_IDX_CTRL, 8'h06, `WIT_RESP_OKAY);
      wr(`WIT_IDX_CTRL, 8'h0f, `WIT_RESP_OKAY);
      rises = 0;
      wait_rises(30);
      wr(`WIT_IDX_CTRL, 8'h07, `WIT_RESP_OKAY);
      wait_rises(100);
      chk("irq", 32'h0, {31'h0, irq});
      rd(`WIT_IDX_STAT, 8'h00, `WIT_RESP_OKAY);
      // Clear code ignored while disabled
      wr(`WIT_IDX_CTRL, 8'ha6, `WIT_RESP_OKAY);
      rd(`WIT_IDX_CTRL, 8'h06, `WIT_RESP_OKAY);
      // Watchdog mode, interval 64
      wr(`WIT_IDX_CTRL, 8'h0b, `WIT_RESP_OKAY);
      rises = 0;
      wr(`WIT_IDX_CTRL, 8'h03, `WIT_RESP_OKAY);
      wr(`WIT_IDX_CTRL, 8'h0f, `WIT_RESP_OKAY);
      rd(`WIT_IDX_CTRL, 8'h0b, `WIT_RESP_OKAY);
      repeat (4) begin
         wait_rises(40);
         clr_pair();
      end
      chk("sysrst", 32'h0, {31'h0, sysrst});
      // Second code too late: no clear
      wait_rises(20);
      wr(`WIT_IDX_CTRL, 8'hab, `WIT_RESP_OKAY);
      repeat (60) @(posedge aclk);
      wr(`WIT_IDX_CTRL, 8'h5b, `WIT_RESP_OKAY);
      wait_hi(1'b1, 4000);
      chk("rises", 32'h1, {31'h0, rises >= 63 && rises <= 65});
      repeat (50) @(posedge aclk);
      chk("sysrst", 32'h1, {31'h0, sysrst});
      chk("irq", 32'h0, {31'h0, irq});
      // Only a system reset ends the request
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("sysrst", 32'h0, {31'h0, sysrst});
      rd(`WIT_IDX_CTRL, 8'h00, `WIT_RESP_OKAY);
      final_report();
   end

   // Watchdog against a hang
   initial begin
      #600000;
      miscompares++;
      final_report();
   end
endmodule // wit_top_tb

`default_nettype wire
